//--- src/ppc_top.sv
// peripheral power control register with apb slave and enable decode
// assumes pclk at 125 MHz, presetn for system resets, por_n only at power-on
//
// Our own choice: the APB register port.
`include "ppc_defines.svh"

module ppc_top (
	// clock and resets
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              por_n,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// operating mode and flash option
	input  wire ppc_pkg::ppc_mode_type op_mode,
	input  wire logic              brownout_always_on,
	// analog detector output
	input  wire logic              low_voltage_raw,
	// circuit enables
	output logic                   lowpower_amp_en,
	output logic                   low_voltage_detector_en,
	output logic                   brownout_detector_en,
	output logic                   temp_sensor_en,
	output logic                   cmp_a_en,
	output logic                   cmp_b_en
);
	import ppc_pkg::*;

	// -----------------------------------------------------------
	// declarations
	// -----------------------------------------------------------
	logic [7:0]   ctrl_r;
	logic [7:0]   ctrl_nxt;
	logic [7:0]   stat_w;
	logic         ao_r;
	logic         low_voltage_sync;
	ppc_apb_type  apb_r;
	logic         wr_done;
	logic         ctrl_hit;
	logic         stat_hit;
	logic         bus_err;
	logic [31:0]  rd_word;
	logic         first_r;

	// -----------------------------------------------------------
	// decode functions
	// -----------------------------------------------------------
	function automatic logic is_stop(input ppc_mode_type m);
		is_stop = (m == PPC_MODE_STOP);
	endfunction

	// brown-out enable from monitor bit, option and mode
	function automatic logic bod_on(input logic off, input logic ao, input ppc_mode_type m);
		if (ao) begin
			bod_on = 1'b1;
		end else if (is_stop(m)) begin
			bod_on = 1'b0;
		end else begin
			bod_on = !off;
		end
	endfunction

	// byte lane 0 merge of a write
	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		merge_byte = st[0] ? (wd[7:0] & `PPC_CTRL_MASK) : old;
	endfunction

	// -----------------------------------------------------------
	// input conditioning
	// -----------------------------------------------------------
	ppc_sync u_lv_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (low_voltage_raw),
		.sync_out (low_voltage_sync)
	);

	// flash option, cleared by power-on reset, then sampled from brownout_always_on every cycle
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			ao_r <= 1'b0;
		end else begin
			ao_r <= brownout_always_on;
		end
	end

	// -----------------------------------------------------------
	// apb address decode
	// -----------------------------------------------------------
	always_comb begin
		ctrl_hit = 1'b0;
		stat_hit = 1'b0;
		if (paddr == `PPC_ADDR_CTRL) begin
			ctrl_hit = 1'b1;
		end else if (paddr == `PPC_ADDR_STAT) begin
			stat_hit = 1'b1;
		end
	end

	// unmapped, or write to the read-only status word
	assign bus_err = !(ctrl_hit || stat_hit) || (stat_hit && pwrite);
	assign wr_done = psel && penable && pready && pwrite && ctrl_hit;

	// -----------------------------------------------------------
	// status word
	// -----------------------------------------------------------
	always_comb begin
		stat_w                    = `PPC_ZERO8;
		stat_w[`PPC_STAT_LV]      = low_voltage_sync && low_voltage_detector_en;
		stat_w[`PPC_STAT_AO]      = ao_r;
		stat_w[`PPC_STAT_LVD_EN]  = low_voltage_detector_en;
		stat_w[`PPC_STAT_BOD_EN]  = brownout_detector_en;
		stat_w[`PPC_STAT_MODE_HI:`PPC_STAT_MODE_LO] = op_mode;
	end

	always_comb begin
		rd_word = `PPC_ZERO32;
		if (ctrl_hit) begin
			rd_word[7:0] = ctrl_r;
		end else if (stat_hit) begin
			rd_word[7:0] = stat_w;
		end
	end

	// -----------------------------------------------------------
	// apb handshake: one wait-free access phase
	// -----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_r   <= PPC_APB_IDLE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `PPC_ZERO32;
		end else begin
			case (apb_r)
				PPC_APB_IDLE: begin
					if (psel && !penable) begin
						apb_r   <= PPC_APB_ANSWER;
						pready  <= 1'b1;
						pslverr <= bus_err;
						prdata  <= (pwrite || bus_err) ? `PPC_ZERO32 : rd_word;
					end
				end
				PPC_APB_ANSWER: begin
					apb_r   <= PPC_APB_IDLE;
					pready  <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					apb_r  <= PPC_APB_IDLE;
					pready <= 1'b0;
				end
			endcase
		end
	end

	// -----------------------------------------------------------
	// power control register, power-on reset only
	// -----------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_done) begin
			ctrl_nxt = merge_byte(ctrl_r, pwdata, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			ctrl_r <= `PPC_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// -----------------------------------------------------------
	// circuit enables
	// -----------------------------------------------------------
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			lowpower_amp_en         <= 1'b0;
			low_voltage_detector_en <= 1'b1;
			brownout_detector_en    <= 1'b1;
			temp_sensor_en          <= 1'b1;
			cmp_a_en                <= 1'b1;
			cmp_b_en                <= 1'b1;
		end else begin
			lowpower_amp_en         <= !ctrl_r[`PPC_BIT_OPAMP];
			low_voltage_detector_en <= !ctrl_r[`PPC_BIT_SUPPLY];
			brownout_detector_en    <= bod_on(ctrl_r[`PPC_BIT_SUPPLY], ao_r, op_mode);
			temp_sensor_en          <= !ctrl_r[`PPC_BIT_TEMP];
			cmp_a_en                <= !ctrl_r[`PPC_BIT_CMP_A];
			cmp_b_en                <= !ctrl_r[`PPC_BIT_CMP_B];
		end
	end

	// -----------------------------------------------------------
	// assertion helpers
	// -----------------------------------------------------------
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end

	// -----------------------------------------------------------
	// assertions
	// -----------------------------------------------------------
	property p_por_default;
		@(posedge pclk) disable iff (!por_n)
		first_r |-> (ctrl_r == `PPC_CTRL_RST) && !lowpower_amp_en;
	endproperty
	a_por_default: assert property (p_por_default)
		else $error("control register not at default after power-on");

	property p_sys_reset_keeps;
		@(posedge pclk) disable iff (!por_n)
		!presetn |=> $stable(ctrl_r);
	endproperty
	a_sys_reset_keeps: assert property (p_sys_reset_keeps)
		else $error("system reset changed the control register");

	property p_write_lands;
		@(posedge pclk) disable iff (!por_n || !presetn)
		(psel && penable && pready && pwrite && (paddr == `PPC_ADDR_CTRL) && pstrb[0])
		|=> ctrl_r == ($past(pwdata[7:0]) & `PPC_CTRL_MASK);
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("control write did not store masked data");

	property p_opamp;
		@(posedge pclk) disable iff (!por_n)
		ctrl_r[`PPC_BIT_OPAMP] |=> !lowpower_amp_en ##1 1'b1;
	endproperty
	a_opamp: assert property (p_opamp)
		else $error("op amp enabled while disabled by control bit");

	property p_lvd;
		@(posedge pclk) disable iff (!por_n)
		1'b1 |=> low_voltage_detector_en == !$past(ctrl_r[`PPC_BIT_SUPPLY]);
	endproperty
	a_lvd: assert property (p_lvd)
		else $error("low-voltage detector enable does not follow monitor bit");

	property p_bod_ao;
		@(posedge pclk) disable iff (!por_n)
		ao_r |=> brownout_detector_en;
	endproperty
	a_bod_ao: assert property (p_bod_ao)
		else $error("brown-out off while always-on option set");

	property p_bod_stop;
		@(posedge pclk) disable iff (!por_n)
		(!ao_r && op_mode == PPC_MODE_STOP) |=> !brownout_detector_en;
	endproperty
	a_bod_stop: assert property (p_bod_stop)
		else $error("brown-out on in stop without always-on option");

	property p_bod_run;
		@(posedge pclk) disable iff (!por_n)
		(!ao_r && op_mode != PPC_MODE_STOP)
		|=> brownout_detector_en == !$past(ctrl_r[`PPC_BIT_SUPPLY]);
	endproperty
	a_bod_run: assert property (p_bod_run)
		else $error("brown-out enable wrong in active or halt");

	property p_small_en;
		@(posedge pclk) disable iff (!por_n)
		1'b1 |=> {temp_sensor_en, cmp_a_en, cmp_b_en} ==
			~{$past(ctrl_r[`PPC_BIT_TEMP]), $past(ctrl_r[`PPC_BIT_CMP_A]),
			$past(ctrl_r[`PPC_BIT_CMP_B])};
	endproperty
	a_small_en: assert property (p_small_en)
		else $error("sensor or comparator enable does not follow its bit");

	property p_lv_flag;
		@(posedge pclk) disable iff (!presetn || !por_n)
		!low_voltage_detector_en |-> !stat_w[`PPC_STAT_LV];
	endproperty
	a_lv_flag: assert property (p_lv_flag)
		else $error("low-voltage flag set while detector disabled");

	property p_apb_answer;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("apb answer not exactly one cycle after setup");

	property p_opamp_on;
		@(posedge pclk) disable iff (!por_n)
		!ctrl_r[`PPC_BIT_OPAMP] |=> lowpower_amp_en;
	endproperty
	a_opamp_on: assert property (p_opamp_on)
		else $error("op amp disabled while its control bit is clear");

	property p_strobe_off;
		@(posedge pclk) disable iff (!por_n || !presetn)
		(psel && penable && pready && pwrite && !pstrb[0]) |=> $stable(ctrl_r);
	endproperty
	a_strobe_off: assert property (p_strobe_off)
		else $error("control register changed by a write without lane 0 strobe");

	property p_refused;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pready
			&& (((paddr != `PPC_ADDR_CTRL) && (paddr != `PPC_ADDR_STAT))
			|| (pwrite && (paddr == `PPC_ADDR_STAT))))
		|-> pslverr && (prdata == `PPC_ZERO32);
	endproperty
	a_refused: assert property (p_refused)
		else $error("refused access not answered with error and zero data");

	// settled detector output, synchroniser out of reset long enough
	property p_lv_live;
		@(posedge pclk) disable iff (!presetn || !por_n)
		(low_voltage_detector_en && $past(presetn, 4)
			&& (low_voltage_raw == $past(low_voltage_raw, 1))
			&& (low_voltage_raw == $past(low_voltage_raw, 2))
			&& (low_voltage_raw == $past(low_voltage_raw, 3))
			&& (low_voltage_raw == $past(low_voltage_raw, 4)))
		|-> stat_w[`PPC_STAT_LV] == low_voltage_raw;
	endproperty
	a_lv_live: assert property (p_lv_live)
		else $error("low-voltage flag does not follow a settled detector output");

endmodule // ppc_top

//--- src/ppc_defines.svh
// register map, field positions and reset values of the power control block
// assumes inclusion by the package and by the block's own modules
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define PPC_AW            12
`define PPC_ADDR_CTRL     12'hF80
`define PPC_ADDR_STAT     12'hF84

// ---------------------------------------------------------------
// power_control_0 fields
// ---------------------------------------------------------------
`define PPC_BIT_OPAMP     7
`define PPC_BIT_SUPPLY    4
`define PPC_BIT_TEMP      3
`define PPC_BIT_CMP_A     1
`define PPC_BIT_CMP_B     0
`define PPC_CTRL_RST      8'h80
`define PPC_CTRL_MASK     8'h9B

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define PPC_STAT_LV       0
`define PPC_STAT_AO       1
`define PPC_STAT_LVD_EN   2
`define PPC_STAT_BOD_EN   3
`define PPC_STAT_MODE_LO  4
`define PPC_STAT_MODE_HI  5

// ---------------------------------------------------------------
// misc constants
// ---------------------------------------------------------------
`define PPC_ZERO8         8'h00
`define PPC_ZERO32        32'h0000_0000

`endif

//--- src/ppc_pkg.sv
// types shared by the power control block
// assumes the defines header sits beside it
`include "ppc_defines.svh"

package ppc_pkg;

	// -----------------------------------------------------------
	// operating modes, driven by the stop/halt entry logic
	// -----------------------------------------------------------
	typedef enum logic [1:0] {
		PPC_MODE_ACTIVE = 2'b00,
		PPC_MODE_HALT   = 2'b01,
		PPC_MODE_STOP   = 2'b10
	} ppc_mode_type;

	// -----------------------------------------------------------
	// apb slave phases
	// -----------------------------------------------------------
	typedef enum logic {
		PPC_APB_IDLE   = 1'b0,
		PPC_APB_ANSWER = 1'b1
	} ppc_apb_type;

endpackage

//--- src/ppc_sync.sv
// three-stage synchroniser with agreement filter for one asynchronous level
// assumes the input comes from outside the pclk domain
module ppc_sync (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// level in and out
	input  wire logic async_in,
	output logic      sync_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// change taken once second and third stage agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_out <= 1'b0;
		end else if (s2_r == s3_r) begin
			sync_out <= s3_r;
		end
	end
endmodule // ppc_sync

//--- verification/tb_top.sv
// self-checking bench for the peripheral power control block
// assumes ppc_pkg and ppc_defines.svh compiled first; assertions live in the design
`include "ppc_defines.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ppc_pkg::*;

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;
		logic [1:0] mode;
		logic       ao;
		logic [5:0] en;
	} ppc_row_type;

	logic         pclk, presetn, por_n, psel, penable, pwrite, ao, lv_raw;
	logic         pready, pslverr, err;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [3:0]   pstrb;
	wire  [5:0]   en;
	ppc_mode_type op_mode;
	int           miscompares, num_checks;

	// ctrl, mode, option, {amp, lvd, bod, temp, cmp_a, cmp_b}
	ppc_row_type rows [11] = '{
		'{8'h80, 2'h0, 1'b0, 6'h1F}, '{8'h00, 2'h2, 1'b0, 6'h37},
		'{8'h10, 2'h0, 1'b0, 6'h27}, '{8'h10, 2'h1, 1'b1, 6'h2F},
		'{8'h90, 2'h2, 1'b1, 6'h0F}, '{8'h00, 2'h1, 1'b0, 6'h3F},
		'{8'h08, 2'h0, 1'b0, 6'h3B}, '{8'h02, 2'h2, 1'b0, 6'h35},
		'{8'h01, 2'h0, 1'b1, 6'h3E}, '{8'h9B, 2'h0, 1'b0, 6'h00},
		'{8'h00, 2'h3, 1'b0, 6'h3F}};

	ppc_top i_dut (
		.pclk(pclk), .presetn(presetn), .por_n(por_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .op_mode(op_mode), .brownout_always_on(ao),
		.low_voltage_raw(lv_raw), .lowpower_amp_en(en[5]),
		.low_voltage_detector_en(en[4]), .brownout_detector_en(en[3]),
		.temp_sensor_en(en[2]), .cmp_a_en(en[1]), .cmp_b_en(en[0]));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic give_verdict();
		if (miscompares == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		{presetn, por_n, psel, penable, pwrite, ao, lv_raw} = 7'h00;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		pstrb   = 4'hF;
		op_mode = PPC_MODE_ACTIVE;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		por_n   <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("reset_en", {26'h0, en}, 32'h0000_001F);
		apb(1'b0, `PPC_ADDR_CTRL, 32'h0);
		chk("reset_ctrl", rd, 32'h0000_0080);
		foreach (rows[i]) begin
			op_mode <= ppc_mode_type'(rows[i].mode);
			ao      <= rows[i].ao;
			apb(1'b1, `PPC_ADDR_CTRL, {24'h0, rows[i].ctrl});
			repeat (3) @(posedge pclk);
			chk("enables", {26'h0, en}, {26'h0, rows[i].en});
			apb(1'b0, `PPC_ADDR_CTRL, 32'h0);
			chk("ctrl", rd, {24'h0, rows[i].ctrl & `PPC_CTRL_MASK});
			chk("ctrl_err", {31'h0, err}, 32'h0000_0000);
			apb(1'b0, `PPC_ADDR_STAT, 32'h0);
			chk("status", rd, {26'h0, rows[i].mode, rows[i].en[3], rows[i].en[4], rows[i].ao, 1'b0});
		end
		// refused accesses and masked strobe
		apb(1'b0, 12'h000, 32'h0);
		chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
		apb(1'b1, `PPC_ADDR_STAT, 32'h0000_00FF);
		chk("ro_write", {31'h0, err}, 32'h0000_0001);
		apb(1'b1, `PPC_ADDR_CTRL, 32'h0000_001B);
		pstrb <= 4'h0;
		apb(1'b1, `PPC_ADDR_CTRL, 32'h0000_0000);
		pstrb <= 4'hF;
		apb(1'b0, `PPC_ADDR_CTRL, 32'h0);
		chk("strobe", rd, 32'h0000_001B);
		// system reset keeps the register, power-on reset restores the 0x80 default
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `PPC_ADDR_CTRL, 32'h0);
		chk("sys_reset", rd, 32'h0000_001B);
		chk("sys_reset_en", {26'h0, en}, 32'h0000_0020);
		por_n <= 1'b0;
		repeat (3) @(posedge pclk);
		por_n <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("por_en", {26'h0, en}, 32'h0000_001F);
		apb(1'b0, `PPC_ADDR_CTRL, 32'h0);
		chk("por_ctrl", rd, 32'h0000_0080);
		// live low-voltage flag, gated by detector enable
		lv_raw <= 1'b1;
		apb(1'b1, `PPC_ADDR_CTRL, 32'h0000_0000);
		repeat (6) @(posedge pclk);
		apb(1'b0, `PPC_ADDR_STAT, 32'h0);
		chk("lv_on", {31'h0, rd[0]}, 32'h0000_0001);
		apb(1'b1, `PPC_ADDR_CTRL, 32'h0000_0010);
		repeat (6) @(posedge pclk);
		apb(1'b0, `PPC_ADDR_STAT, 32'h0);
		chk("lv_gated", {31'h0, rd[0]}, 32'h0000_0000);
		lv_raw <= 1'b0;
		apb(1'b1, `PPC_ADDR_CTRL, 32'h0000_0000);
		repeat (6) @(posedge pclk);
		apb(1'b0, `PPC_ADDR_STAT, 32'h0);
		chk("lv_live", {31'h0, rd[0]}, 32'h0000_0000);
		give_verdict();
	end

	// watchdog, far beyond the few hundred cycles the tests take
	initial begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		give_verdict();
	end
endmodule // tb_top
